// ---- hdl/clm_top.sv ----
// Purpose: component life monitor with APB registers and wear alarms
// Assumes: hour_tick and power_up_pulse are asynchronous pin inputs
// Notes: percentages refresh a few dozen cycles after a count moves
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module clm_top #(
  parameter int NUM_OUT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hour_tick,
  input wire logic fan_running,
  input wire logic bus_charged,
  input wire logic power_up_pulse,
  input wire logic igbt_cycle,
  output logic [NUM_OUT-1:0] output_terminal,
  output clm_pkg::clm_events_type keypad_alarm,
  output logic irq
);
  import clm_pkg::*;

  // ==========================================================
  // pin synchronisers
  // a pin level only moves once stages two and three agree
  function automatic logic settle(input logic [2:0] s, input logic q);
    if (s[2] && s[1]) begin
      return 1'b1;
    end
    if (!s[2] && !s[1]) begin
      return 1'b0;
    end
    return q;
  endfunction

  logic [2:0] tick_s_r;
  logic [2:0] pwr_s_r;
  logic [2:0] fan_s_r;
  logic [2:0] bus_s_r;
  logic [2:0] igbt_s_r;
  // followers reset low like an idle pin, so no false edge
  logic tick_q_r;
  logic pwr_q_r;
  logic igbt_q_r;
  logic fan_q_r;
  logic bus_q_r;
  wire logic tick_lvl = settle(tick_s_r, tick_q_r);
  wire logic pwr_lvl = settle(pwr_s_r, pwr_q_r);
  wire logic igbt_lvl = settle(igbt_s_r, igbt_q_r);
  wire logic fan_on = settle(fan_s_r, fan_q_r);
  wire logic bus_on = settle(bus_s_r, bus_q_r);
  wire logic tick_rise = tick_lvl & ~tick_q_r;
  wire logic pwr_rise = pwr_lvl & ~pwr_q_r;
  wire logic igbt_rise = igbt_lvl & ~igbt_q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s_r <= 3'h0;
      pwr_s_r <= 3'h0;
      fan_s_r <= 3'h0;
      bus_s_r <= 3'h0;
      igbt_s_r <= 3'h0;
      tick_q_r <= 1'b0;
      pwr_q_r <= 1'b0;
      igbt_q_r <= 1'b0;
      fan_q_r <= 1'b0;
      bus_q_r <= 1'b0;
    end else begin
      tick_s_r <= {tick_s_r[1:0], hour_tick};
      pwr_s_r <= {pwr_s_r[1:0], power_up_pulse};
      fan_s_r <= {fan_s_r[1:0], fan_running};
      bus_s_r <= {bus_s_r[1:0], bus_charged};
      igbt_s_r <= {igbt_s_r[1:0], igbt_cycle};
      tick_q_r <= tick_lvl;
      pwr_q_r <= pwr_lvl;
      igbt_q_r <= igbt_lvl;
      fan_q_r <= fan_on;
      bus_q_r <= bus_on;
    end
  end

  // ==========================================================
  // apb decode
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic a_ctrl = paddr == CLM_OFS_CTRL;
  wire logic a_reset = paddr == CLM_OFS_RESET;
  wire logic a_outsel = paddr == CLM_OFS_OUTSEL;
  wire logic a_clr = paddr == CLM_OFS_IRQ_CLR;
  wire logic a_en = paddr == CLM_OFS_IRQ_EN;
  wire logic a_fper = paddr == CLM_OFS_FAN_PERIOD;
  wire logic a_cper = paddr == CLM_OFS_CAP_PERIOD;
  wire logic a_rper = paddr == CLM_OFS_RLY_PERIOD;
  wire logic a_iper = paddr == CLM_OFS_IGBT_PERIOD;
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= CLM_OFS_IGBT_COUNT);
  wire logic [3:0] rst_req = (wr & a_reset) ? pwdata[3:0] : 4'h0;

  // ==========================================================
  // software registers
  logic [3:0] ctrl_r;
  logic [23:0] outsel_r;
  logic [3:0] irq_en_r;
  logic [31:0] period_r [4];
  logic [31:0] prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 4'h0;
      outsel_r <= 24'h0;
      irq_en_r <= 4'h0;
      period_r[CLM_MON_FAN] <= CLM_FAN_PERIOD_RST;
      period_r[CLM_MON_CAP] <= CLM_CAP_PERIOD_RST;
      period_r[CLM_MON_RLY] <= CLM_RLY_PERIOD_RST;
      period_r[CLM_MON_IGBT] <= CLM_IGBT_PERIOD_RST;
    end else if (wr) begin
      if (a_ctrl) ctrl_r <= pwdata[3:0];
      if (a_outsel) outsel_r <= pwdata[23:0];
      if (a_en) irq_en_r <= pwdata[3:0];
      if (a_fper) period_r[CLM_MON_FAN] <= pwdata;
      if (a_cper) period_r[CLM_MON_CAP] <= pwdata;
      if (a_rper) period_r[CLM_MON_RLY] <= pwdata;
      if (a_iper) period_r[CLM_MON_IGBT] <= pwdata;
    end
  end

  // ==========================================================
  // life counters
  logic [31:0] cnt_r [4];
  wire logic [3:0] inc = {igbt_rise, pwr_rise, tick_rise & bus_on,
                          tick_rise & fan_on};
  wire logic fan_wrap = cnt_r[CLM_MON_FAN] >= {15'h0, CLM_FAN_HOURS_MAX};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) cnt_r[i] <= 32'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // a clear beats a same-cycle increment
        if (rst_req[i]) begin
          cnt_r[i] <= 32'h0;
        end else if (inc[i]) begin
          cnt_r[i] <= cnt_r[i] + 32'h1;
        end
      end
      // top count reached: the next hour wraps to zero
      if (!rst_req[CLM_MON_FAN] && inc[CLM_MON_FAN] && fan_wrap) begin
        cnt_r[CLM_MON_FAN] <= 32'h0;
      end
    end
  end

  // ==========================================================
  // percentage engines, restarted on any count or period change
  logic [31:0] seen_r [4];
  logic [31:0] seen_p_r [4];
  logic [15:0] pct [4];
  logic [3:0] busy;
  logic [3:0] start;

  for (genvar g = 0; g < 4; g++) begin : g_pct
    assign start[g] = !busy[g] &&
      (seen_r[g] != cnt_r[g] || seen_p_r[g] != period_r[g]);
    // count taken live at start; period copy held while busy
    clm_pct_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(start[g]),
      .count(cnt_r[g]),
      .period(seen_p_r[g]),
      .busy(busy[g]),
      .pct(pct[g])
    );
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        seen_r[g] <= 32'h0;
        seen_p_r[g] <= 32'h0;
      end else if (!busy[g]) begin
        seen_r[g] <= cnt_r[g];
        seen_p_r[g] <= period_r[g];
      end
    end
  end

  // ==========================================================
  // wear detection and outputs
  // threshold test shared by the four monitors
  function automatic logic reached(input logic [15:0] p,
                                   input logic [15:0] lim);
    return p >= lim;
  endfunction

  // six-bit function code of one output terminal
  function automatic logic [5:0] code_of(input logic [23:0] sel,
                                         input int o);
    return sel[6*o +: 6];
  endfunction

  wire logic fan_wear = reached(pct[CLM_MON_FAN], CLM_PCT_WEAR);
  wire logic cap_wear = reached(pct[CLM_MON_CAP], CLM_PCT_WEAR);
  wire logic rly_wear = reached(pct[CLM_MON_RLY], CLM_PCT_WEAR);
  wire logic igbt_wear = reached(pct[CLM_MON_IGBT], CLM_PCT_IGBT);
  wire logic maint_any = fan_wear | cap_wear | rly_wear | igbt_wear;
  logic [NUM_OUT-1:0] is_maint;
  logic [NUM_OUT-1:0] is_alarm;
  for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
    assign is_maint[o] = code_of(outsel_r, o) == CLM_FN_MAINT;
    assign is_alarm[o] = code_of(outsel_r, o) == CLM_FN_ALARM;
  end
  wire logic maint_cfg = |is_maint;
  // ctrl bit set marks that alarm as unconditional
  wire logic [3:0] wear = {igbt_wear, rly_wear, cap_wear, fan_wear};
  wire logic [3:0] shown = wear & (ctrl_r | {4{maint_cfg}});
  wire logic alarm_any = |shown[2:0];

  logic [NUM_OUT-1:0] out_r;
  clm_events_type kp_r;
  logic [3:0] irq_st_r;
  logic [3:0] shown_q_r;
  wire logic [3:0] rise = shown & ~shown_q_r;
  wire logic [3:0] clr = (wr & a_clr) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '0;
      kp_r <= '0;
      irq_st_r <= 4'h0;
      shown_q_r <= 4'h0;
    end else begin
      out_r <= (is_maint & {NUM_OUT{maint_any}}) |
               (is_alarm & {NUM_OUT{alarm_any}});
      kp_r <= '{fan: shown[0], cap: shown[1], rly: shown[2], igbt: 1'b0};
      shown_q_r <= shown;
      // a new alarm beats a same-cycle clear
      irq_st_r <= rise | (irq_st_r & ~clr);
    end
  end

  assign output_terminal = out_r;
  assign keypad_alarm = kp_r;
  assign irq = |(irq_st_r & irq_en_r);

  // ==========================================================
  // read mux
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0;
    case (paddr)
      CLM_OFS_CTRL: rd = {28'h0, ctrl_r};
      CLM_OFS_FAN_HOURS: rd = cnt_r[CLM_MON_FAN];
      CLM_OFS_FAN_PCT: rd = {16'h0, pct[CLM_MON_FAN]};
      CLM_OFS_CAP_PCT: rd = {16'h0, pct[CLM_MON_CAP]};
      CLM_OFS_RLY_PCT: rd = {16'h0, pct[CLM_MON_RLY]};
      CLM_OFS_IGBT_PCT: rd = {16'h0, pct[CLM_MON_IGBT]};
      CLM_OFS_OUTSEL: rd = {8'h0, outsel_r};
      CLM_OFS_ALARM: rd = {24'h0, wear, 1'b0, shown[2:0]};
      CLM_OFS_IRQ_STAT: rd = {28'h0, irq_st_r};
      CLM_OFS_IRQ_EN: rd = {28'h0, irq_en_r};
      CLM_OFS_FAN_PERIOD: rd = period_r[CLM_MON_FAN];
      CLM_OFS_CAP_PERIOD: rd = period_r[CLM_MON_CAP];
      CLM_OFS_RLY_PERIOD: rd = period_r[CLM_MON_RLY];
      CLM_OFS_IGBT_PERIOD: rd = period_r[CLM_MON_IGBT];
      CLM_OFS_CAP_HOURS: rd = cnt_r[CLM_MON_CAP];
      CLM_OFS_RLY_COUNT: rd = cnt_r[CLM_MON_RLY];
      CLM_OFS_IGBT_COUNT: rd = cnt_r[CLM_MON_IGBT];
      default: rd = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd;
    end
  end

  // read word captured in the setup cycle, steady in access
  assign prdata = prdata_r;
  // zero wait states; unmapped or unaligned words are refused
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
endmodule

// ---- hdl/clm_pkg.sv ----
// Purpose: shared constants and types for the component life monitor
// Assumes: 32-bit APB, one clock pclk at 250 MHz
// Notes: offsets are byte addresses of aligned words
package clm_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] CLM_OFS_CTRL = 8'h00;
  localparam logic [7:0] CLM_OFS_FAN_HOURS = 8'h04;
  localparam logic [7:0] CLM_OFS_FAN_PCT = 8'h08;
  localparam logic [7:0] CLM_OFS_CAP_PCT = 8'h0c;
  localparam logic [7:0] CLM_OFS_RLY_PCT = 8'h10;
  localparam logic [7:0] CLM_OFS_IGBT_PCT = 8'h14;
  localparam logic [7:0] CLM_OFS_RESET = 8'h18;
  localparam logic [7:0] CLM_OFS_OUTSEL = 8'h1c;
  localparam logic [7:0] CLM_OFS_ALARM = 8'h20;
  localparam logic [7:0] CLM_OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] CLM_OFS_IRQ_CLR = 8'h28;
  localparam logic [7:0] CLM_OFS_IRQ_EN = 8'h2c;
  localparam logic [7:0] CLM_OFS_FAN_PERIOD = 8'h30;
  localparam logic [7:0] CLM_OFS_CAP_PERIOD = 8'h34;
  localparam logic [7:0] CLM_OFS_RLY_PERIOD = 8'h38;
  localparam logic [7:0] CLM_OFS_IGBT_PERIOD = 8'h3c;
  localparam logic [7:0] CLM_OFS_CAP_HOURS = 8'h40;
  localparam logic [7:0] CLM_OFS_RLY_COUNT = 8'h44;
  localparam logic [7:0] CLM_OFS_IGBT_COUNT = 8'h48;
  // ==========================================================
  // counter limits and thresholds
  localparam logic [16:0] CLM_FAN_HOURS_MAX = 17'h1869f;
  localparam logic [15:0] CLM_PCT_WEAR = 16'h005a;
  localparam logic [15:0] CLM_PCT_IGBT = 16'h0032;
  localparam logic [15:0] CLM_PCT_MAX = 16'hffff;
  localparam logic [7:0] CLM_PCT_SCALE = 8'h64;
  localparam logic [5:0] CLM_FN_MAINT = 6'h2f;
  localparam logic [5:0] CLM_FN_ALARM = 6'h10;
  // ==========================================================
  // reset values of the maintenance periods
  localparam logic [31:0] CLM_FAN_PERIOD_RST = 32'h0000ab18;
  localparam logic [31:0] CLM_CAP_PERIOD_RST = 32'h0000ab18;
  localparam logic [31:0] CLM_RLY_PERIOD_RST = 32'h000186a0;
  localparam logic [31:0] CLM_IGBT_PERIOD_RST = 32'h000186a0;
  // ==========================================================
  // monitor indices and interrupt bits
  localparam int CLM_MON_FAN = 0;
  localparam int CLM_MON_CAP = 1;
  localparam int CLM_MON_RLY = 2;
  localparam int CLM_MON_IGBT = 3;
  localparam int CLM_NUM_OUT = 4;

  typedef struct packed {
    logic fan;
    logic cap;
    logic rly;
    logic igbt;
  } clm_events_type;

  typedef enum logic [2:0] {
    CLM_ST_IDLE = 3'b001,
    CLM_ST_DIV = 3'b010,
    CLM_ST_DONE = 3'b100
  } clm_div_state_type;
endpackage

// ---- hdl/clm_pct_div.sv ----
// Purpose: serial divider giving count*100/period, saturating
// Assumes: start is a one-cycle pulse; period held while busy
// Notes: count read at start only; 42 cycles per result
`timescale 1ns/1ps
module clm_pct_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [31:0] count,
  input wire logic [31:0] period,
  output logic busy,
  output logic [15:0] pct
);
  import clm_pkg::*;
  clm_div_state_type state_r;
  logic [39:0] num_r;
  logic [39:0] rem_r;
  logic [39:0] quo_r;
  logic [5:0] bit_r;
  logic [15:0] pct_r;
  wire logic [39:0] rem_sh = {rem_r[38:0], num_r[39]};
  wire logic [39:0] per_ext = {8'h00, period};
  wire logic fits = rem_sh >= per_ext;
  wire logic [39:0] scaled = {8'h00, count} * {32'h0, CLM_PCT_SCALE};
  wire logic over = quo_r[39:16] != 24'h000000;

  // ==========================================================
  // divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CLM_ST_IDLE;
      num_r <= 40'h0;
      rem_r <= 40'h0;
      quo_r <= 40'h0;
      bit_r <= 6'h0;
      pct_r <= 16'h0;
    end else begin
      case (state_r)
        CLM_ST_IDLE: begin
          if (start) begin
            num_r <= scaled;
            rem_r <= 40'h0;
            quo_r <= 40'h0;
            bit_r <= 6'h28;
            state_r <= CLM_ST_DIV;
          end
        end
        CLM_ST_DIV: begin
          num_r <= {num_r[38:0], 1'b0};
          rem_r <= fits ? rem_sh - per_ext : rem_sh;
          quo_r <= {quo_r[38:0], fits};
          bit_r <= bit_r - 6'h1;
          if (bit_r == 6'h1) begin
            state_r <= CLM_ST_DONE;
          end
        end
        CLM_ST_DONE: begin
          // saturate rather than wrap
          if (period == 32'h0 || over) begin
            pct_r <= CLM_PCT_MAX;
          end else begin
            pct_r <= quo_r[15:0];
          end
          state_r <= CLM_ST_IDLE;
        end
        default: begin
          state_r <= CLM_ST_IDLE;
        end
      endcase
    end
  end

  assign busy = state_r != CLM_ST_IDLE;
  assign pct = pct_r;
endmodule

// ---- tb/clm_props.sv ----
// Purpose: port checks of the life monitor
// Assumes: terminal i code sits at outsel bits 6i+5..6i
// Notes: ctrl and outsel are shadowed from apb writes
`timescale 1ns/1ps
module clm_props import clm_pkg::*; #(
  parameter int NUM_OUT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_OUT-1:0] output_terminal,
  input wire clm_pkg::clm_events_type keypad_alarm,
  input wire logic irq
);
  // ==========================================================
  // shadow of written config
  logic [23:0] outsel_r;
  logic [3:0] ctrl_r;
  logic maint_any;
  wire wr_take = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outsel_r <= '0;
      ctrl_r <= '0;
    end else if (wr_take && paddr == CLM_OFS_OUTSEL) begin
      outsel_r <= pwdata[23:0];
    end else if (wr_take && paddr == CLM_OFS_CTRL) begin
      ctrl_r <= pwdata[3:0];
    end
  end
  always_comb begin
    maint_any = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) begin
      maint_any = maint_any | (outsel_r[6*i +: 6] == CLM_FN_MAINT);
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_alarm_up;
    $rose(|keypad_alarm[3:1]);
  endsequence
  sequence s_fan_cond;
    keypad_alarm.fan && !ctrl_r[0] && !$past(ctrl_r[0]);
  endsequence
  chk_pready_zero: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_bad_addr: assert property (psel && penable
    && (paddr > CLM_OFS_IGBT_COUNT
    || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (psel && paddr <= CLM_OFS_IGBT_COUNT
    && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  chk_prdata_hold: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata))
    else $error("read data moved outside a read");
  chk_irq_mask: assert property (wr_take && paddr == CLM_OFS_IRQ_EN
    && pwdata == 32'h0 |=> !irq)
    else $error("irq high with all enables off");
  chk_reset_quiet: assert property ($rose(presetn) |->
    output_terminal == '0 && keypad_alarm == '0 && !irq)
    else $error("outputs active after reset");
  chk_cond_shown: assert property (s_fan_cond |->
    maint_any || $past(maint_any) || $past(maint_any, 2))
    else $error("conditional alarm shown without maint output");
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_term
    wire [5:0] code = outsel_r[6*i +: 6];
    chk_alarm_term: assert property ((code == CLM_FN_ALARM)
      ##0 s_alarm_up |-> ##[0:2] output_terminal[i])
      else $error("alarm terminal did not follow alarm");
    chk_idle_term: assert property (code != CLM_FN_MAINT
      && code != CLM_FN_ALARM && $past(code) == code
      && $past(code, 2) == code |-> !output_terminal[i])
      else $error("unassigned terminal closed");
  end
endmodule

// ---- tb/clm_far.sv ----
// Purpose: pin-side model making hour and power-up edges
// Assumes: pulses far longer than the pin synchroniser
// Notes: lines rest low between pulses
`timescale 1ns/1ps
module clm_far (
  input wire logic pclk,
  output logic hour_tick,
  output logic power_up_pulse
);
  initial begin
    hour_tick = 1'b0;
    power_up_pulse = 1'b0;
  end
  // one rising edge per hour or per power-up
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (which == 0) hour_tick <= 1'b1;
      else power_up_pulse <= 1'b1;
      repeat (8) @(posedge pclk);
      hour_tick <= 1'b0;
      power_up_pulse <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
endmodule

// ---- tb/tb_component_life_monitor.sv ----
// Purpose: self-checking bench of the life monitor
// Assumes: outsel terminal i at bits 6i+5..6i
// Notes: reads are checked in order by a monitor process
`timescale 1ns/1ps
module tb_component_life_monitor;
  import clm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fan_running = 1'b0;
  logic bus_charged = 1'b0;
  logic igbt_cycle = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hour_tick;
  logic power_up_pulse;
  logic [3:0] output_terminal;
  clm_events_type keypad_alarm;
  logic irq;
  logic [32:0] exp_q[$];
  logic [31:0] rnd = 32'h48da;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2 pclk = ~pclk;
  clm_top #(.NUM_OUT(4)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hour_tick(hour_tick),
    .fan_running(fan_running), .bus_charged(bus_charged),
    .power_up_pulse(power_up_pulse), .igbt_cycle(igbt_cycle),
    .output_terminal(output_terminal), .keypad_alarm(keypad_alarm),
    .irq(irq));
  clm_far far_u (.pclk(pclk), .hour_tick(hour_tick),
    .power_up_pulse(power_up_pulse));
  // ==========================================================
  // tasks
  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [32:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // ==========================================================
  // read monitor
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
        && pwrite === 1'b0 && exp_q.size() > 0)
      check("prdata", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    pause(20000);
    n_mismatch++;
    test_done();
  end
  // ==========================================================
  // main sequence
  initial begin
    pause(12);
    presetn <= 1'b1;
    apb(0, CLM_OFS_FAN_PERIOD, {1'b0, CLM_FAN_PERIOD_RST});
    apb(0, CLM_OFS_RLY_PERIOD, {1'b0, CLM_RLY_PERIOD_RST});
    apb(0, CLM_OFS_CTRL, 33'h0);
    apb(0, 8'h4c, 33'h100000000);
    rnd = xorshift(rnd);
    apb(1, CLM_OFS_IGBT_PERIOD, {1'b0, rnd});
    apb(0, CLM_OFS_IGBT_PERIOD, {1'b0, rnd});
    apb(1, CLM_OFS_FAN_PERIOD, 33'd10);
    apb(1, CLM_OFS_CAP_PERIOD, 33'd1);
    apb(1, CLM_OFS_RLY_PERIOD, 33'd10);
    fan_running <= 1'b1;
    far_u.pulse(0, 9);
    pause(150);
    apb(0, CLM_OFS_FAN_HOURS, 33'd9);
    apb(0, CLM_OFS_FAN_PCT, 33'd90);
    apb(0, CLM_OFS_CAP_HOURS, 33'd0);
    check("keypad_alarm", keypad_alarm, 33'h0);
    apb(1, CLM_OFS_IRQ_EN, 33'hf);
    apb(1, CLM_OFS_OUTSEL, 33'h42f);
    pause(4);
    check("keypad_alarm", keypad_alarm, 33'h8);
    check("output_terminal", output_terminal, 33'h3);
    check("irq", irq, 33'h1);
    apb(1, CLM_OFS_IRQ_EN, 33'h0);
    pause(1);
    check("irq", irq, 33'h0);
    apb(1, CLM_OFS_IRQ_EN, 33'hf);
    pause(1);
    check("irq", irq, 33'h1);
    apb(1, CLM_OFS_IRQ_CLR, 33'hf);
    pause(1);
    check("irq", irq, 33'h0);
    apb(1, CLM_OFS_OUTSEL, 33'h0);
    apb(1, CLM_OFS_CTRL, 33'h1);
    pause(4);
    check("keypad_alarm", keypad_alarm, 33'h8);
    check("output_terminal", output_terminal, 33'h0);
    far_u.pulse(0, 1);
    pause(150);
    apb(0, CLM_OFS_FAN_HOURS, 33'd10);
    apb(0, CLM_OFS_FAN_PCT, 33'd100);
    apb(1, CLM_OFS_RESET, 33'h1);
    apb(0, CLM_OFS_FAN_HOURS, 33'd0);
    pause(150);
    apb(0, CLM_OFS_FAN_PCT, 33'd0);
    fan_running <= 1'b0;
    bus_charged <= 1'b1;
    far_u.pulse(0, 3);
    apb(1, CLM_OFS_CTRL, 33'h2);
    pause(150);
    apb(0, CLM_OFS_CAP_HOURS, 33'd3);
    apb(0, CLM_OFS_CAP_PCT, 33'd300);
    apb(0, CLM_OFS_FAN_HOURS, 33'd0);
    check("keypad_alarm", keypad_alarm, 33'h4);
    far_u.pulse(1, 9);
    apb(1, CLM_OFS_CTRL, 33'h4);
    pause(150);
    apb(0, CLM_OFS_RLY_COUNT, 33'd9);
    apb(0, CLM_OFS_RLY_PCT, 33'd90);
    check("keypad_alarm", keypad_alarm, 33'h2);
    apb(1, CLM_OFS_RESET, 33'h6);
    apb(1, CLM_OFS_OUTSEL, 33'h2f);
    apb(1, CLM_OFS_IGBT_PERIOD, 33'd2);
    pause(150);
    check("output_terminal", output_terminal, 33'h0);
    igbt_cycle <= 1'b1;
    pause(8);
    igbt_cycle <= 1'b0;
    pause(150);
    apb(0, CLM_OFS_IGBT_COUNT, 33'd1);
    apb(0, CLM_OFS_IGBT_PCT, 33'd50);
    check("output_terminal", output_terminal, 33'h1);
    check("keypad_alarm", keypad_alarm, 33'h0);
    apb(1, CLM_OFS_FAN_PERIOD, 33'h0);
    pause(150);
    apb(0, CLM_OFS_FAN_PCT, 33'hffff);
    check("keypad_alarm", keypad_alarm, 33'h8);
    pause(4);
    test_done();
  end
endmodule
bind clm_top clm_props #(.NUM_OUT(NUM_OUT)) props_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .output_terminal(output_terminal),
  .keypad_alarm(keypad_alarm), .irq(irq));
